// *** rtl/timer8_waveform_output_control.sv ***
// Top of the eight-bit timer waveform unit: Avalon-MM register slave,
// counter, two compare output channels and the pin multiplexers.
// Assumes port data and direction come from logic on the same clock.
//
// Operation
// R1: Nonzero channel A field puts wave A on its pin; driven only if direction out. Field 01 in modes 1 and 3 leaves the port on the pin.
// R2: Nonzero channel B field puts wave B on its pin; driven only if direction out.
// R3: Non-PWM channel A on match: 00 off, 01 toggle, 10 clear, 11 set.
// R4: Non-PWM channel B on match: 00 off, 01 toggle, 10 clear, 11 set.
// R5: Fast PWM A: 10 clear match/set bottom, 11 inverse, 01 toggles if high bit.
// R6: Phase PWM A: 10 clear up/set down, 11 inverse, 01 toggles if high bit.
// R7: Fast PWM B: 10 clear match/set bottom, 11 inverse, 01 reserved.
// R8: Phase PWM B: 10 clear up/set down, 11 inverse, 01 reserved.
// R9: Fast PWM, compare equals top, field high bit set: ignore match, keep bottom action.
// R10: Phase PWM, compare equals top, field high bit set: ignore match, act at top.
// R11: Control bits 3 and 2 are reserved and read zero.
// R12: Mode is high bit from control B joined with two low bits here.
// R13: Modes 0 and 2: top 0xFF or compare A, immediate load, overflow at max.
// R14: Modes 1 and 5: phase PWM, top 0xFF or compare A, load top, overflow bottom.
// R15: Modes 3 and 7: fast PWM, load at bottom, overflow at max or top.
// R16: Software must not select the reserved modes 4 and 6.
// R17: Max count is 0xFF and bottom is 0x00.
// R18: Phase PWM counts up to top, holds it one cycle, then down.
// R19: Channel B field 01 in PWM leaves the pin with normal port function.
`timescale 1ns/1ps
`include "timer8_regs.svh"
module timer8_waveform_output_control (
  input wire logic I_CLK_SYS, // System clock, 250 MHz
  input wire logic I_ARST_N, // Async reset, active low
  input wire logic [7:0] I_AVS_ADDRESS, // Byte address
  input wire logic I_AVS_READ, // Read request
  input wire logic I_AVS_WRITE, // Write request
  input wire logic [31:0] I_AVS_WRITEDATA, // Write data
  input wire logic [3:0] I_AVS_BYTEENABLE, // Byte lanes
  output logic [31:0] O_AVS_READDATA, // Read data, registered
  output logic O_AVS_WAITREQUEST, // Wait request
  input wire logic I_PORT_A_DATA, // Port level for pin A
  input wire logic I_PORT_A_DIR, // Pin A direction, 1 = out
  input wire logic I_PORT_B_DATA, // Port level for pin B
  input wire logic I_PORT_B_DIR, // Pin B direction, 1 = out
  output logic O_PIN_A, // Pin A level
  output logic O_PIN_A_OE_N, // Pin A enable, low drives
  output logic O_PIN_B, // Pin B level
  output logic O_PIN_B_OE_N, // Pin B enable, low drives
  output logic O_OVERFLOW_FLAG // Sticky overflow flag
);
  timer8_if tif ();

  logic ack_r, ack_nxt;
  logic [7:0] ctrl_a_r, ctrl_a_nxt, ctrl_b_r, ctrl_b_nxt;
  logic [7:0] cmp_a_sw_r, cmp_a_sw_nxt, cmp_b_sw_r, cmp_b_sw_nxt;
  logic ovf_r, ovf_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic access, wr_take, rd_start, ovf_evt;
  logic [1:0] mode_a, mode_b;
  logic wave_a, wave_b, conn_a, conn_b;

  // One wait cycle per access: read data are latched in the first cycle
  // and stand when waitrequest drops, so no combinational read path exists.
  assign access = I_AVS_READ | I_AVS_WRITE;
  assign O_AVS_WAITREQUEST = access & ~ack_r;
  assign rd_start = I_AVS_READ & ~ack_r;
  assign wr_take = I_AVS_WRITE & ack_r & I_AVS_BYTEENABLE[0];
  assign O_AVS_READDATA = rdata_r;
  assign O_OVERFLOW_FLAG = ovf_r;

  // Field extraction and mode assembly
  assign mode_a = ctrl_a_r[`CHAN_A_MODE_HI:`CHAN_A_MODE_LO];
  assign mode_b = ctrl_a_r[`CHAN_B_MODE_HI:`CHAN_B_MODE_LO];
  assign tif.mode = {ctrl_b_r[`MODE_HIGH_BIT], ctrl_a_r[`MODE_LOW_HI:`MODE_LOW_LO]}; // [R12]

  // Bus decode, register writes and overflow flag
  always_comb begin
    ack_nxt = access & ~ack_r;
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    cmp_a_sw_nxt = cmp_a_sw_r;
    cmp_b_sw_nxt = cmp_b_sw_r;
    ovf_nxt = ovf_r;
    rdata_nxt = rdata_r;
    if (rd_start) begin
      if (I_AVS_ADDRESS == `OFS_CTRL_A) begin
        rdata_nxt = {`PAD_ZERO, ctrl_a_r & `CTRL_A_WMASK}; // Reserved bits zero [R11]
      end else if (I_AVS_ADDRESS == `OFS_CTRL_B) begin
        rdata_nxt = {`PAD_ZERO, ctrl_b_r & `CTRL_B_WMASK};
      end else if (I_AVS_ADDRESS == `OFS_CMP_A) begin
        rdata_nxt = {`PAD_ZERO, cmp_a_sw_r};
      end else if (I_AVS_ADDRESS == `OFS_CMP_B) begin
        rdata_nxt = {`PAD_ZERO, cmp_b_sw_r};
      end else if (I_AVS_ADDRESS == `OFS_COUNT) begin
        rdata_nxt = {`PAD_ZERO, tif.cnt};
      end else if (I_AVS_ADDRESS == `OFS_STATUS) begin
        rdata_nxt = {`PAD_ZERO, 7'h00, ovf_r};
      end else begin
        rdata_nxt = `BUS_ZERO; // Unmapped reads zero
      end
    end
    if (wr_take) begin
      if (I_AVS_ADDRESS == `OFS_CTRL_A) begin
        ctrl_a_nxt = I_AVS_WRITEDATA[7:0] & `CTRL_A_WMASK; // [R11]
      end else if (I_AVS_ADDRESS == `OFS_CTRL_B) begin
        ctrl_b_nxt = I_AVS_WRITEDATA[7:0] & `CTRL_B_WMASK;
      end else if (I_AVS_ADDRESS == `OFS_CMP_A) begin
        cmp_a_sw_nxt = I_AVS_WRITEDATA[7:0];
      end else if (I_AVS_ADDRESS == `OFS_CMP_B) begin
        cmp_b_sw_nxt = I_AVS_WRITEDATA[7:0];
      end else if (I_AVS_ADDRESS == `OFS_STATUS) begin
        if (I_AVS_WRITEDATA[`OVF_BIT]) begin
          ovf_nxt = 1'b0; // Write one to clear
        end
      end
    end
    // Set after clear so a same-cycle event is never lost
    if (ovf_evt) begin
      ovf_nxt = 1'b1; // [R13] [R14] [R15]
    end
  end

  // Register bank
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ack_r <= 1'b0;
      ctrl_a_r <= `REG_RESET;
      ctrl_b_r <= `REG_RESET;
      cmp_a_sw_r <= `REG_RESET;
      cmp_b_sw_r <= `REG_RESET;
      ovf_r <= 1'b0;
      rdata_r <= `BUS_ZERO;
    end else begin
      ack_r <= ack_nxt;
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      cmp_a_sw_r <= cmp_a_sw_nxt;
      cmp_b_sw_r <= cmp_b_sw_nxt;
      ovf_r <= ovf_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Counter with top select and compare buffers
  timer8_counter u_counter (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_sw_cmp_a(cmp_a_sw_r),
    .i_sw_cmp_b(cmp_b_sw_r),
    .tif(tif.ctr),
    .o_ovf_evt(ovf_evt)
  );

  // Channel A may toggle in PWM when the mode high bit is set
  timer8_wave_chan #(
    .TOGGLE_IN_PWM(1'b1)
  ) u_chan_a (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_cmp(tif.cmp_a),
    .i_out_mode(mode_a),
    .tif(tif.chan),
    .o_wave(wave_a),
    .o_connected(conn_a)
  );

  // Channel B treats 01 as reserved in PWM
  timer8_wave_chan #(
    .TOGGLE_IN_PWM(1'b0)
  ) u_chan_b (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_cmp(tif.cmp_b),
    .i_out_mode(mode_b),
    .tif(tif.chan),
    .o_wave(wave_b),
    .o_connected(conn_b)
  );

  // Pin override; the direction bit alone gates the driver, so a
  // connected wave stays invisible while the pin is an input.
  assign O_PIN_A = conn_a ? wave_a : I_PORT_A_DATA; // [R1]
  assign O_PIN_A_OE_N = ~I_PORT_A_DIR; // [R1]
  assign O_PIN_B = conn_b ? wave_b : I_PORT_B_DATA; // [R2] [R19]
  assign O_PIN_B_OE_N = ~I_PORT_B_DIR; // [R2]

  pin_a_mux_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N) // [R1]
    (O_PIN_A_OE_N == !I_PORT_A_DIR) &&
    ((mode_a != 2'b00 && tif.mode == `MODE_NORMAL) ? (O_PIN_A == wave_a) : 1'b1))
    else $error("pin A not fed from wave");
  pin_b_mux_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N) // [R2]
    (mode_b != 2'b00 && tif.mode == `MODE_NORMAL) |->
    (O_PIN_B == wave_b && O_PIN_B_OE_N == !I_PORT_B_DIR)) else $error("pin B not fed from wave");
  rsvd_b_port_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N) // [R19]
    (mode_b == 2'b01 && (tif.mode == `MODE_FAST_FF || tif.mode == `MODE_PHASE_CMP)) |->
    (O_PIN_B == I_PORT_B_DATA)) else $error("reserved B field took the pin");
  rsvd_read_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N) // [R11]
    (I_AVS_READ && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == `OFS_CTRL_A) |->
    (O_AVS_READDATA[3:2] == 2'b00)) else $error("reserved control bits read nonzero");
  ovf_sticky_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N) // [R13]
    ovf_evt |=> ovf_r) else $error("overflow event lost");
  max_ovf_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N) // [R17]
    (tif.mode == `MODE_NORMAL && tif.cnt == `CNT_MAX) |=> (ovf_r && tif.cnt == `CNT_BOTTOM))
    else $error("no overflow at max");
  wait_len_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    (access && !ack_r) |-> O_AVS_WAITREQUEST ##1 (!O_AVS_WAITREQUEST || !access))
    else $error("access not answered in two cycles");

  fast_run_c: cover property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    tif.mode == `MODE_FAST_FF && mode_a == 2'b10 && tif.cnt == `CNT_MAX ##1 wave_a);
  phase_turn_c: cover property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    tif.mode == `MODE_PHASE_FF && tif.cnt == `CNT_MAX ##1 !tif.up);
  ovf_clear_c: cover property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
    ovf_r ##1 !ovf_r);
endmodule

// *** rtl/timer8_regs.svh ***
// Register map, field positions, reset values and mode codes of the timer.
// Included by bare name; definitions only.
`ifndef TIMER8_REGS_SVH
`define TIMER8_REGS_SVH

// Byte offsets on the register bus
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_CMP_A 8'h08
`define OFS_CMP_B 8'h0C
`define OFS_COUNT 8'h10
`define OFS_STATUS 8'h14

// Field positions
`define CHAN_A_MODE_HI 7
`define CHAN_A_MODE_LO 6
`define CHAN_B_MODE_HI 5
`define CHAN_B_MODE_LO 4
`define MODE_LOW_HI 1
`define MODE_LOW_LO 0
`define MODE_HIGH_BIT 3
`define OVF_BIT 0

// Writable bits; all others read as zero
`define CTRL_A_WMASK 8'hF3
`define CTRL_B_WMASK 8'h08
`define REG_RESET 8'h00
`define BUS_ZERO 32'h00000000
`define PAD_ZERO 24'h000000

// Counter limits
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`define CNT_STEP 8'h01

// Waveform mode codes
`define MODE_NORMAL 3'h0
`define MODE_PHASE_FF 3'h1
`define MODE_CLR_MATCH 3'h2
`define MODE_FAST_FF 3'h3
`define MODE_PHASE_CMP 3'h5
`define MODE_FAST_CMP 3'h7

`endif

// *** rtl/timer8_pkg.sv ***
// Types shared by the timer modules.
// Assumes timer8_regs.svh for the mode codes.
`include "timer8_regs.svh"
package timer8_pkg;
  typedef enum logic [1:0] {WK_NORMAL, WK_FAST, WK_PHASE} wave_kind_t;

  // Counting family of a three-bit mode; reserved codes count as normal
  function automatic wave_kind_t wave_kind(input logic [2:0] mode);
    wave_kind_t k;
    k = WK_NORMAL;
    if (mode == `MODE_PHASE_FF || mode == `MODE_PHASE_CMP) begin
      k = WK_PHASE;
    end else if (mode == `MODE_FAST_FF || mode == `MODE_FAST_CMP) begin
      k = WK_FAST;
    end
    return k;
  endfunction

  // Modes whose top is compare A
  function automatic logic top_from_cmp_a(input logic [2:0] mode);
    return (mode == `MODE_CLR_MATCH) || (mode == `MODE_PHASE_CMP) || (mode == `MODE_FAST_CMP);
  endfunction
endpackage

// *** rtl/timer8_if.sv ***
// Counter state shared between the counter and the two output channels.
// Mode is driven by the top module from its control registers.
`timescale 1ns/1ps
interface timer8_if;
  logic [2:0] mode; // Three-bit waveform mode
  logic [7:0] cnt; // Current count
  logic [7:0] top; // Active top value
  logic up; // Direction of the next step
  logic [7:0] cmp_a; // Active compare A
  logic [7:0] cmp_b; // Active compare B

  modport ctr (input mode, output cnt, output top, output up, output cmp_a, output cmp_b);
  modport chan (input mode, input cnt, input top, input up);
endinterface

// *** rtl/timer8_counter.sv ***
// Eight-bit counter with top selection, compare buffering and overflow event.
// Assumes a count step on every clock; no prescaler in front of it.
`timescale 1ns/1ps
`include "timer8_regs.svh"
module timer8_counter (
  input wire logic i_clk, // Timer clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [7:0] i_sw_cmp_a, // Compare A as written
  input wire logic [7:0] i_sw_cmp_b, // Compare B as written
  timer8_if.ctr tif, // Shared counter state
  output logic o_ovf_evt // Overflow event, one cycle
);
  timer8_pkg::wave_kind_t kind;
  logic top_is_a, at_top, at_bottom;
  logic [7:0] cnt_r, cnt_nxt, cmp_a_r, cmp_a_nxt, cmp_b_r, cmp_b_nxt;
  logic up_r, up_nxt;

  // Decode of mode and limits
  assign kind = timer8_pkg::wave_kind(tif.mode);
  assign top_is_a = timer8_pkg::top_from_cmp_a(tif.mode);
  assign tif.top = top_is_a ? cmp_a_r : `CNT_MAX;
  assign at_top = (cnt_r == tif.top);
  assign at_bottom = (cnt_r == `CNT_BOTTOM);
  assign tif.cnt = cnt_r;
  assign tif.up = up_nxt;
  assign tif.cmp_a = cmp_a_r;
  assign tif.cmp_b = cmp_b_r;

  // Count sequence, buffer reload and overflow per family
  always_comb begin
    cnt_nxt = cnt_r;
    up_nxt = up_r;
    cmp_a_nxt = cmp_a_r;
    cmp_b_nxt = cmp_b_r;
    o_ovf_evt = 1'b0;
    case (kind)
      timer8_pkg::WK_PHASE: begin
        if (up_r) begin
          if (at_top) begin // Top held one cycle, then down [R18]
            up_nxt = 1'b0;
            cnt_nxt = at_bottom ? `CNT_BOTTOM : 8'(cnt_r - `CNT_STEP);
          end else begin
            cnt_nxt = 8'(cnt_r + `CNT_STEP);
          end
        end else if (at_bottom) begin
          up_nxt = 1'b1;
          cnt_nxt = at_top ? `CNT_BOTTOM : 8'(cnt_r + `CNT_STEP);
        end else begin
          cnt_nxt = 8'(cnt_r - `CNT_STEP);
        end
        if (at_top) begin // Reload at top [R14]
          cmp_a_nxt = i_sw_cmp_a;
          cmp_b_nxt = i_sw_cmp_b;
        end
        o_ovf_evt = at_bottom & ~up_r; // Overflow at bottom [R14]
      end
      timer8_pkg::WK_FAST: begin
        up_nxt = 1'b1;
        cnt_nxt = at_top ? `CNT_BOTTOM : 8'(cnt_r + `CNT_STEP);
        if (at_top) begin // Reload as count returns to bottom [R15]
          cmp_a_nxt = i_sw_cmp_a;
          cmp_b_nxt = i_sw_cmp_b;
        end
        o_ovf_evt = top_is_a ? at_top : (cnt_r == `CNT_MAX); // [R15] [R17]
      end
      default: begin
        up_nxt = 1'b1;
        cnt_nxt = at_top ? `CNT_BOTTOM : 8'(cnt_r + `CNT_STEP); // [R13]
        cmp_a_nxt = i_sw_cmp_a; // Immediate update [R13]
        cmp_b_nxt = i_sw_cmp_b;
        o_ovf_evt = (cnt_r == `CNT_MAX); // [R13] [R17]
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= `CNT_BOTTOM;
      up_r <= 1'b1;
      cmp_a_r <= `REG_RESET;
      cmp_b_r <= `REG_RESET;
    end else begin
      cnt_r <= cnt_nxt;
      up_r <= up_nxt;
      cmp_a_r <= cmp_a_nxt;
      cmp_b_r <= cmp_b_nxt;
    end
  end

  phase_turn_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R18]
    (kind == timer8_pkg::WK_PHASE && up_r && at_top && !at_bottom) |=>
    (!up_r && cnt_r == 8'($past(cnt_r) - `CNT_STEP))) else $error("phase count did not turn");
  imm_load_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R13]
    (kind == timer8_pkg::WK_NORMAL && $past(kind) == timer8_pkg::WK_NORMAL) |->
    (cmp_a_r == $past(i_sw_cmp_a))) else $error("compare A not loaded at once");
  fast_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R15]
    (kind == timer8_pkg::WK_FAST && !at_top) |=> (cmp_b_r == $past(cmp_b_r)))
    else $error("fast compare reloaded away from bottom");
  phase_ovf_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R14]
    (kind == timer8_pkg::WK_PHASE) |-> (o_ovf_evt == (at_bottom && !up_r)))
    else $error("phase overflow not at bottom");
endmodule

// *** rtl/timer8_wave_chan.sv ***
// One compare output channel: match, bottom and top actions on the wave.
// Assumes the counter state of timer8_counter on the same clock.
`timescale 1ns/1ps
`include "timer8_regs.svh"
module timer8_wave_chan #(
  parameter bit TOGGLE_IN_PWM = 1'b1 // Channel may toggle in PWM modes with the mode high bit set
) (
  input wire logic i_clk, // Timer clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [7:0] i_cmp, // Active compare value
  input wire logic [1:0] i_out_mode, // Output-mode field
  timer8_if.chan tif, // Shared counter state
  output logic o_wave, // Waveform level, registered
  output logic o_connected // Wave owns the pin
);
  timer8_pkg::wave_kind_t kind;
  logic match, at_top, cmp_is_top, toggle_ok, wave_r, wave_nxt;

  assign kind = timer8_pkg::wave_kind(tif.mode);
  assign match = (tif.cnt == i_cmp);
  assign at_top = (tif.cnt == tif.top);
  assign cmp_is_top = (i_cmp == tif.top);
  assign toggle_ok = TOGGLE_IN_PWM && tif.mode[2];
  assign o_wave = wave_r;

  // Field 01 in PWM stays off the pin unless toggling is allowed [R19]
  assign o_connected = (i_out_mode != 2'b00) &&
    !(kind != timer8_pkg::WK_NORMAL && i_out_mode == 2'b01 && !toggle_ok);

  // Next wave level per counting family
  always_comb begin
    wave_nxt = wave_r;
    case (kind)
      timer8_pkg::WK_FAST: begin
        if (i_out_mode[1]) begin
          if (at_top) begin // Bottom action as count wraps [R5] [R7]
            wave_nxt = ~i_out_mode[0];
          end else if (match && !cmp_is_top) begin // Match at top ignored [R9]
            wave_nxt = i_out_mode[0];
          end
        end else if (i_out_mode[0] && toggle_ok && match) begin // [R5]
          wave_nxt = ~wave_r;
        end
      end
      timer8_pkg::WK_PHASE: begin
        if (i_out_mode[1]) begin
          if (cmp_is_top) begin
            if (at_top) begin // Action done at top instead [R10]
              wave_nxt = ~i_out_mode[0];
            end
          end else if (match) begin // Up clears or sets, down inverse [R6] [R8]
            wave_nxt = tif.up ? i_out_mode[0] : ~i_out_mode[0];
          end
        end else if (i_out_mode[0] && toggle_ok && match) begin // [R6]
          wave_nxt = ~wave_r;
        end
      end
      default: begin
        if (match) begin // Toggle, clear, set on match [R3] [R4]
          case (i_out_mode)
            2'b01: wave_nxt = ~wave_r;
            2'b10: wave_nxt = 1'b0;
            2'b11: wave_nxt = 1'b1;
            default: wave_nxt = wave_r;
          endcase
        end
      end
    endcase
  end

  // Wave register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wave_r <= 1'b0;
    end else begin
      wave_r <= wave_nxt;
    end
  end

  fast_bottom_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R5] [R7]
    (kind == timer8_pkg::WK_FAST && i_out_mode == 2'b10 && at_top) |=> o_wave)
    else $error("fast non-inverting not set at bottom");
  match_toggle_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R3] [R4]
    (kind == timer8_pkg::WK_NORMAL && i_out_mode == 2'b01 && match) |=>
    (o_wave != $past(o_wave))) else $error("no toggle on match");
  top_ignore_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R9]
    (kind == timer8_pkg::WK_FAST && i_out_mode[1] && cmp_is_top && at_top) |=>
    (o_wave == !$past(i_out_mode[0]))) else $error("match at top not ignored");
  phase_up_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R6] [R8]
    (kind == timer8_pkg::WK_PHASE && i_out_mode == 2'b10 && match && !cmp_is_top) |=>
    (o_wave == !$past(tif.up))) else $error("phase match action wrong");
endmodule

// *** tb/timer8_waveform_output_control_bench.sv ***
// Self-checking bench for the eight-bit timer waveform unit.
// Drives the Avalon-MM slave and port inputs itself; pins are judged directly.
`timescale 1ns/1ps
`include "timer8_regs.svh"
module timer8_waveform_output_control_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] av_adr = 8'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wd = 32'h00000000;
  logic [31:0] av_rdata;
  logic av_wait;
  logic pa_data = 1'b0, pa_dir = 1'b1, pb_data = 1'b0, pb_dir = 1'b1;
  logic pin_a, pin_a_oe_n, pin_b, pin_b_oe_n, ovf;
  int failures = 0;
  int checks_done = 0;
  int seed = 32'h8DBE5460;
  int h, top, n;
  logic [31:0] q;
  logic [7:0] ca, cb;
  logic [7:0] rst_adr [6] = '{`OFS_CTRL_A, `OFS_CTRL_B, `OFS_CMP_A, `OFS_CMP_B, `OFS_STATUS, 8'h3C};
  logic [2:0] pwm_modes [4] = '{3'h3, 3'h1, 3'h7, 3'h5};
  logic [2:0] ovf_modes [5] = '{3'h0, 3'h3, 3'h7, 3'h1, 3'h5};

  // Free-running 250 MHz clock
  always #2 clk = ~clk;

  timer8_waveform_output_control i_timer8_waveform_output_control (
    .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_AVS_ADDRESS(av_adr), .I_AVS_READ(av_rd),
    .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd), .I_AVS_BYTEENABLE(4'hF),
    .O_AVS_READDATA(av_rdata), .O_AVS_WAITREQUEST(av_wait), .I_PORT_A_DATA(pa_data),
    .I_PORT_A_DIR(pa_dir), .I_PORT_B_DATA(pb_data), .I_PORT_B_DIR(pb_dir), .O_PIN_A(pin_a),
    .O_PIN_A_OE_N(pin_a_oe_n), .O_PIN_B(pin_b), .O_PIN_B_OE_N(pin_b_oe_n),
    .O_OVERFLOW_FLAG(ovf)
  );

  // Verdict in one place; also reached by the watchdog
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One transfer; request held until waitrequest is seen low, then released.
  // No cycle count is assumed here: only the watchdog ends a hung wait.
  task automatic bus(input bit wr, input logic [7:0] a, input logic [7:0] d);
    av_adr <= a;
    av_wd <= {`PAD_ZERO, d};
    av_wr <= wr;
    av_rd <= !wr;
    do begin
      @(posedge clk);
    end while (av_wait !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Compares first so a PWM mode never starts on stale values
  task automatic cfg(input logic [2:0] m, input logic [1:0] fa, input logic [1:0] fb,
                     input int settle);
    bus(1'b1, `OFS_CMP_A, ca);
    bus(1'b1, `OFS_CMP_B, cb);
    bus(1'b1, `OFS_CTRL_B, {4'h0, m[2], 3'h0}); // Call order keeps codes 4 and 6 unused
    bus(1'b1, `OFS_CTRL_A, {fa, fb, 2'h0, m[1:0]});
    repeat (settle) @(posedge clk);
  endtask

  // Random port levels and directions must reach the pins untouched
  task automatic port_chk();
    repeat (6) begin
      {pa_data, pa_dir, pb_data, pb_dir} <= 4'($random(seed));
      @(posedge clk);
      chk("pin_a", {31'h0, pa_data}, {31'h0, pin_a});
      chk("oe_a", {31'h0, ~pa_dir}, {31'h0, pin_a_oe_n});
      chk("pin_b", {31'h0, pb_data}, {31'h0, pin_b});
      chk("oe_b", {31'h0, ~pb_dir}, {31'h0, pin_b_oe_n});
    end
  endtask

  task automatic hi_cnt(input bit sel_a, input int len, output int hc);
    hc = 0;
    repeat (len) begin
      @(posedge clk);
      hc += ((sel_a ? pin_a : pin_b) === 1'b1) ? 1 : 0;
    end
  endtask

  // Exactly one match in any window of one period, so the level must flip
  task automatic tog_chk(input bit sel_a, input int per);
    logic w;
    w = sel_a ? pin_a : pin_b;
    repeat (per) @(posedge clk);
    chk("toggle", {31'h0, ~w}, {31'h0, sel_a ? pin_a : pin_b});
  endtask

  function automatic int period(input logic [2:0] m, input int tp);
    return (m == `MODE_FAST_FF || m == `MODE_FAST_CMP) ? tp + 1 : 2 * tp;
  endfunction

  // High cycles per period; compare at top gives a constant level
  function automatic int exp_hi(input logic [2:0] m, input logic [1:0] f, input int c,
                                input int tp);
    int hh;
    hh = (m == `MODE_FAST_FF || m == `MODE_FAST_CMP) ? c + 1 : 2 * c;
    return (f == 2'h2) ? hh : period(m, tp) - hh;
  endfunction

  // Watchdog sized well above the roughly 50k cycles of the sequence
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // Reset values, then reserved bits and the unmapped hole
    foreach (rst_adr[i]) begin
      bus(1'b0, rst_adr[i], 8'h00);
      chk("reset", `BUS_ZERO, q);
    end
    bus(1'b1, `OFS_CTRL_A, 8'hFF);
    bus(1'b0, `OFS_CTRL_A, 8'h00);
    chk("ctrl_a", 32'h000000F3, q);
    bus(1'b1, `OFS_CTRL_B, 8'hFF);
    bus(1'b0, `OFS_CTRL_B, 8'h00);
    chk("ctrl_b", 32'h00000008, q);
    bus(1'b1, 8'h3C, 8'hFF);
    bus(1'b0, 8'h3C, 8'h00);
    chk("hole", `BUS_ZERO, q);
    ca = 8'($random(seed));
    cb = 8'($random(seed));
    cfg(`MODE_NORMAL, 2'h0, 2'h0, 2);
    port_chk();
    // Non-PWM set, clear and toggle; port level opposes the expected wave
    pa_data <= 1'b0;
    pb_data <= 1'b0;
    cfg(`MODE_NORMAL, 2'h3, 2'h3, 300);
    chk("set_a", 32'h1, {31'h0, pin_a});
    chk("set_b", 32'h1, {31'h0, pin_b});
    pa_data <= 1'b1;
    pb_data <= 1'b1;
    cfg(`MODE_NORMAL, 2'h2, 2'h2, 300);
    chk("clr_a", 32'h0, {31'h0, pin_a});
    chk("clr_b", 32'h0, {31'h0, pin_b});
    cfg(`MODE_NORMAL, 2'h1, 2'h1, 10);
    tog_chk(1'b1, 256);
    tog_chk(1'b0, 256);
    // Clear on match: compare A is top, the max count is never reached.
    // Settle long enough for a count left above top to wrap through max.
    ca = 8'h10 + 8'($random(seed)) % 8'h70;
    cfg(`MODE_CLR_MATCH, 2'h1, 2'h0, 300);
    tog_chk(1'b1, ca + 1);
    bus(1'b1, `OFS_STATUS, 8'h01);
    repeat (300) @(posedge clk);
    chk("ovf_ctc", 32'h0, {31'h0, ovf});
    // Duty in every PWM mode and polarity; first round holds the corners
    for (int r = 0; r < 3; r++) begin
      ca = (r == 0) ? 8'hFF : 8'h20 + 8'($random(seed)) % 8'hE0;
      cb = (r == 0) ? 8'h00 : 8'(($random(seed) & 32'h7FFFFFFF) % (ca + 1));
      foreach (pwm_modes[i]) begin
        for (int f = 2; f < 4; f++) begin
          top = pwm_modes[i][2] ? int'(ca) : 255;
          cfg(pwm_modes[i], 2'(f), 2'(f), 1100);
          hi_cnt(1'b1, period(pwm_modes[i], top), h);
          chk("duty_a", exp_hi(pwm_modes[i], 2'(f), ca, top), h);
          hi_cnt(1'b0, period(pwm_modes[i], top), h);
          chk("duty_b", exp_hi(pwm_modes[i], 2'(f), cb, top), h);
        end
      end
    end
    // Field 01 in PWM: port keeps the pin unless A has the high mode bit
    cfg(`MODE_FAST_FF, 2'h1, 2'h1, 10);
    port_chk();
    cfg(`MODE_PHASE_FF, 2'h1, 2'h1, 10);
    port_chk();
    ca = 8'h40;
    cfg(`MODE_FAST_CMP, 2'h1, 2'h0, 600);
    tog_chk(1'b1, 65);
    cfg(`MODE_PHASE_CMP, 2'h1, 2'h0, 1100);
    tog_chk(1'b1, 128);
    // Count read just after the flag rises shows where it was set
    foreach (ovf_modes[i]) begin
      cfg(ovf_modes[i], 2'h0, 2'h0, 600);
      bus(1'b1, `OFS_STATUS, 8'h01);
      n = 0;
      while (ovf !== 1'b0 && n < 600) begin
        @(posedge clk);
        n++;
      end
      if (n >= 600) failures++;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (ovf !== 1'b1 && n < 600);
      if (n >= 600) failures++;
      bus(1'b0, `OFS_COUNT, 8'h00);
      chk("ovf_cnt", (ovf_modes[i][1:0] == 2'b01) ? 32'h2 : 32'h1, q);
    end
    close_out();
  end
endmodule
